/* File: rtl/urxeiw_core.sv */
// Added by the designer: the plain strobed port and the placing of the registers.
`include "urxeiw_defs.svh"
module urxeiw_core (
    input wire logic clk,
    input wire logic resetn,
    input wire urxeiw_pkg::urxeiw_addr_t addr,
    input wire urxeiw_pkg::urxeiw_byte_t wdata,
    input wire logic wr_en,
    input wire logic rd_en,
    output urxeiw_pkg::urxeiw_byte_t rdata,
    input wire logic rx_pin,
    input wire logic clk_on,
    input wire logic halt,
    input wire logic tx_empty,
    input wire logic tx_idle,
    input wire logic global_interrupt_enable,
    input wire logic serial_module_interrupt_enable,
    input wire logic stack_full,
    output logic irq_n,
    output logic vector_req,
    output logic wake_req
);
    import urxeiw_pkg::*;

    // ----------------------------------------
    // Declarations
    // ----------------------------------------
    localparam logic [11:0] STARTUP_CYC = 12'(`URXEIW_STARTUP_CYC);
    urxeiw_byte_t ctrl1_r, ctrl1_nxt, ctrl2_r, ctrl2_nxt, baud_r, baud_nxt, rdata_r, rdata_nxt;
    urxeiw_state_t st_r, st_nxt;
    logic rx_s1_r, rx_s2_r, rx_prev_r;
    logic [7:0] div_r, div_nxt;
    logic [3:0] ovs_r, ovs_nxt, bitn_r, bitn_nxt;
    logic [8:0] shift_r, shift_nxt, data9;
    logic [2:0] smp_r, smp_nxt;
    logic noise_r, noise_nxt, fe_r, fe_nxt, par_r, par_nxt, push;
    urxeiw_entry_t mem_r [2];
    urxeiw_entry_t mem_nxt [2];
    urxeiw_entry_t new_entry, head;
    logic [1:0] cnt_r, cnt_nxt;
    logic wp_r, wp_nxt, rp_r, rp_nxt, oerr_r, oerr_nxt, armed_r, armed_nxt;
    logic txe_prev_r, txi_prev_r, wake_pend_r, wake_pend_nxt;
    logic [11:0] startup_cnt_r, startup_cnt_nxt;
    logic irq_n_r, irq_n_nxt, vector_r, vector_nxt, wake_req_r, wake_req_nxt;
    logic run, tick, bit_end, maj, noisy, rx_fall, rx_go, startup;
    logic stat_rd, data_rd, pop, full, push_ok, ovr, pe_new, rx_evt, evt, wake_hit, wake_evt, ints_on;

    assign run = clk_on & ~halt; // [RULE15] [RULE16]
    assign tick = run & (div_r == 8'h00);
    assign bit_end = (ovs_r == `URXEIW_OVS_LAST);
    assign maj = (smp_r[0] & smp_r[1]) | (smp_r[0] & smp_r[2]) | (smp_r[1] & smp_r[2]);
    assign noisy = ~((&smp_r) | ~(|smp_r));
    assign rx_fall = rx_prev_r & ~rx_s2_r;
    assign rx_go = ctrl1_r[`URXEIW_C1_MODE] & ctrl1_r[`URXEIW_C1_EN] & ctrl2_r[`URXEIW_C2_RXEN];
    assign startup = (startup_cnt_r != 12'h000);
    assign stat_rd = rd_en & (addr == `URXEIW_ADDR_STATUS);
    assign data_rd = rd_en & (addr == `URXEIW_ADDR_DATA);
    assign ints_on = global_interrupt_enable & serial_module_interrupt_enable;

    // ----------------------------------------
    // Register file
    // ----------------------------------------
    always_comb begin
        ctrl1_nxt = ctrl1_r;
        ctrl2_nxt = ctrl2_r;
        baud_nxt = baud_r;
        rdata_nxt = `URXEIW_RST_BYTE;
        // Only bus writes change these, so halt leaves them intact [RULE17]
        if (wr_en) begin
            case (addr)
                `URXEIW_ADDR_CTRL1: ctrl1_nxt = wdata & `URXEIW_C1_WMASK;
                `URXEIW_ADDR_CTRL2: ctrl2_nxt = wdata & `URXEIW_C2_WMASK;
                `URXEIW_ADDR_BAUD: baud_nxt = wdata;
                default: ;
            endcase
        end
        if (rd_en) begin
            case (addr)
                // Status bits are read-only; writes to status are ignored [RULE11]
                `URXEIW_ADDR_STATUS: rdata_nxt = {head[`URXEIW_E_PE], head[`URXEIW_E_NF], head[`URXEIW_E_FE], oerr_r,
                                                  (st_r == ST_IDLE), (cnt_r != 2'h0), tx_idle, tx_empty};
                `URXEIW_ADDR_CTRL1: begin
                    rdata_nxt = ctrl1_r;
                    rdata_nxt[`URXEIW_C1_RX9] = head[8];
                end
                `URXEIW_ADDR_CTRL2: rdata_nxt = ctrl2_r;
                `URXEIW_ADDR_DATA: rdata_nxt = head[7:0];
                `URXEIW_ADDR_BAUD: rdata_nxt = baud_r;
                default: rdata_nxt = `URXEIW_RST_BYTE;
            endcase
        end
    end

    always_ff @(posedge clk) begin
        if (!resetn) begin
            ctrl1_r <= `URXEIW_RST_BYTE;
            ctrl2_r <= `URXEIW_RST_BYTE;
            baud_r <= `URXEIW_RST_BYTE;
            rdata_r <= `URXEIW_RST_BYTE;
        end else begin
            ctrl1_r <= ctrl1_nxt;
            ctrl2_r <= ctrl2_nxt;
            baud_r <= baud_nxt;
            rdata_r <= rdata_nxt;
        end
    end

    // ----------------------------------------
    // Receiver
    // ----------------------------------------
    always_comb begin
        st_nxt = st_r;
        div_nxt = div_r;
        ovs_nxt = ovs_r;
        bitn_nxt = bitn_r;
        shift_nxt = shift_r;
        smp_nxt = smp_r;
        noise_nxt = noise_r;
        fe_nxt = fe_r;
        par_nxt = par_r;
        push = 1'b0;
        if (run) begin
            div_nxt = (div_r == 8'h00) ? baud_r : div_r - 8'h01;
        end
        if (st_r == ST_IDLE) begin
            ovs_nxt = 4'h0;
            bitn_nxt = 4'h0;
            noise_nxt = 1'b0;
            fe_nxt = 1'b0;
            // A held break has no falling edge, so no false start [RULE25] [RULE20]
            if (run && rx_go && rx_fall && !startup) begin
                st_nxt = ST_START;
            end
        end else if (tick) begin
            ovs_nxt = ovs_r + 4'h1;
            if (ovs_r == `URXEIW_SMP_A) smp_nxt[0] = rx_s2_r;
            if (ovs_r == `URXEIW_SMP_B) smp_nxt[1] = rx_s2_r;
            if (ovs_r == `URXEIW_SMP_C) smp_nxt[2] = rx_s2_r;
            if (bit_end) begin
                noise_nxt = noise_r | noisy;
                case (st_r)
                    ST_START: st_nxt = maj ? ST_IDLE : ST_DATA;
                    ST_DATA: begin
                        shift_nxt = {maj, shift_r[8:1]};
                        bitn_nxt = bitn_r + 4'h1;
                        if (bitn_r == (ctrl1_r[`URXEIW_C1_NINE] ? `URXEIW_LAST9 : `URXEIW_LAST8)) begin
                            st_nxt = ctrl1_r[`URXEIW_C1_PEN] ? ST_PAR : ST_STOP1;
                        end
                    end
                    ST_PAR: begin
                        par_nxt = maj;
                        st_nxt = ST_STOP1;
                    end
                    ST_STOP1: begin
                        fe_nxt = ~maj; // [RULE1]
                        if (ctrl1_r[`URXEIW_C1_TWO]) begin
                            st_nxt = ST_STOP2;
                        end else begin
                            push = 1'b1;
                            st_nxt = ST_IDLE;
                        end
                    end
                    ST_STOP2: begin
                        fe_nxt = fe_r | ~maj; // [RULE2]
                        push = 1'b1;
                        st_nxt = ST_IDLE;
                    end
                    default: st_nxt = ST_IDLE;
                endcase
            end
        end
    end

    always_ff @(posedge clk) begin
        if (!resetn) begin
            rx_s1_r <= 1'b1;
            rx_s2_r <= 1'b1;
            rx_prev_r <= 1'b1;
            st_r <= ST_IDLE;
            div_r <= 8'h00;
            ovs_r <= 4'h0;
            bitn_r <= 4'h0;
            shift_r <= 9'h000;
            smp_r <= 3'h7;
            noise_r <= 1'b0;
            fe_r <= 1'b0;
            par_r <= 1'b0;
        end else begin
            rx_s1_r <= rx_pin;
            rx_s2_r <= rx_s1_r;
            rx_prev_r <= rx_s2_r;
            st_r <= st_nxt;
            div_r <= div_nxt;
            ovs_r <= ovs_nxt;
            bitn_r <= bitn_nxt;
            shift_r <= shift_nxt;
            smp_r <= smp_nxt;
            noise_r <= noise_nxt;
            fe_r <= fe_nxt;
            par_r <= par_nxt;
        end
    end

    // ----------------------------------------
    // Receive buffer and flags
    // ----------------------------------------
    assign data9 = ctrl1_r[`URXEIW_C1_NINE] ? shift_nxt : {1'b0, shift_nxt[8:1]};
    assign pe_new = ctrl1_r[`URXEIW_C1_PEN] & ((^{data9, par_r}) ^ ctrl1_r[`URXEIW_C1_ODD]); // [RULE4] [RULE5]
    assign new_entry = {noise_nxt, pe_new, fe_nxt, data9}; // [RULE3] [RULE24] [RULE25]
    assign head = (cnt_r != 2'h0) ? mem_r[rp_r] : 12'h000;
    assign pop = data_rd & (cnt_r != 2'h0);
    assign full = (cnt_r == `URXEIW_FIFO_FULL);
    assign push_ok = push & (~full | pop);
    assign ovr = push & full & ~pop;

    for (genvar g = 0; g < 2; g++) begin : g_entry
        assign mem_nxt[g] = (push_ok && (wp_r == 1'(g))) ? new_entry : mem_r[g];
    end

    always_comb begin
        cnt_nxt = cnt_r + {1'b0, push_ok} - {1'b0, pop};
        wp_nxt = wp_r ^ push_ok;
        rp_nxt = rp_r ^ pop;
        // Status access then data read clears; a new overrun wins [RULE23] [RULE11]
        oerr_nxt = ovr | (oerr_r & ~(data_rd & armed_r));
        armed_nxt = stat_rd | (armed_r & ~data_rd);
    end

    always_ff @(posedge clk) begin
        if (!resetn) begin
            mem_r[0] <= 12'h000;
            mem_r[1] <= 12'h000;
            cnt_r <= 2'h0;
            wp_r <= 1'b0;
            rp_r <= 1'b0;
            oerr_r <= 1'b0;
            armed_r <= 1'b0;
        end else begin
            mem_r[0] <= mem_nxt[0];
            mem_r[1] <= mem_nxt[1];
            cnt_r <= cnt_nxt;
            wp_r <= wp_nxt;
            rp_r <= rp_nxt;
            oerr_r <= oerr_nxt;
            armed_r <= armed_nxt;
        end
    end

    // ----------------------------------------
    // Interrupt request and wake-up
    // ----------------------------------------
    // Data available, address detect and overrun share one enable [RULE9] [RULE10] [RULE12] [RULE13]
    assign rx_evt = ctrl2_r[`URXEIW_C2_RIE] & ((push_ok & (~ctrl2_r[`URXEIW_C2_ADDEN] | shift_nxt[8])) | ovr);
    assign evt = ~startup & (rx_evt | (tx_empty & ~txe_prev_r & ctrl2_r[`URXEIW_C2_TXEIE])
                 | (tx_idle & ~txi_prev_r & ctrl2_r[`URXEIW_C2_TXIIE])); // [RULE7] [RULE9] [RULE22]
    assign wake_hit = ~clk_on & rx_go & ctrl2_r[`URXEIW_C2_RIE] & ctrl2_r[`URXEIW_C2_WAKE]
                      & rx_fall & ~startup & ~wake_pend_r; // [RULE19]
    assign wake_evt = wake_pend_r & (startup_cnt_r == 12'h001) & ints_on; // [RULE21] [RULE22]

    always_comb begin
        startup_cnt_nxt = startup ? startup_cnt_r - 12'h001 : startup_cnt_r;
        wake_pend_nxt = wake_pend_r & startup;
        wake_req_nxt = wake_hit;
        if (wake_hit) begin
            startup_cnt_nxt = STARTUP_CYC;
            wake_pend_nxt = 1'b1;
        end
        irq_n_nxt = ~(evt | wake_evt); // [RULE26]
        vector_nxt = (evt | wake_evt) & ints_on & ~stack_full; // [RULE8]
    end

    always_ff @(posedge clk) begin
        if (!resetn) begin
            txe_prev_r <= 1'b0;
            txi_prev_r <= 1'b0;
            wake_pend_r <= 1'b0;
            startup_cnt_r <= 12'h000;
            irq_n_r <= 1'b1;
            vector_r <= 1'b0;
            wake_req_r <= 1'b0;
        end else begin
            txe_prev_r <= tx_empty;
            txi_prev_r <= tx_idle;
            wake_pend_r <= wake_pend_nxt;
            startup_cnt_r <= startup_cnt_nxt;
            irq_n_r <= irq_n_nxt;
            vector_r <= vector_nxt;
            wake_req_r <= wake_req_nxt;
        end
    end

    assign rdata = rdata_r;
    assign irq_n = irq_n_r;
    assign vector_req = vector_r;
    assign wake_req = wake_req_r;

    // ----------------------------------------
    // Assertions
    // ----------------------------------------
    default clocking cb @(posedge clk); endclocking
    default disable iff (!resetn);

    sequence s_stop1_low;
        st_r == ST_STOP1 && tick && bit_end && !maj;
    endsequence
    sequence s_stop2_low;
        st_r == ST_STOP2 && tick && bit_end && !maj;
    endsequence
    sequence s_frozen;
        !run ##1 1'b1;
    endsequence

    a_frame_err_one: assert property (s_stop1_low and !ctrl1_r[`URXEIW_C1_TWO] |-> push && new_entry[`URXEIW_E_FE]) // [RULE1]
        else $error("stop bit low did not set frame error");
    a_frame_err_two: assert property (s_stop2_low |-> push && new_entry[`URXEIW_E_FE]) // [RULE2]
        else $error("second stop bit low did not set frame error");
    a_flags_reset: assert property ($rose(resetn) |-> rdata_r == 8'h00 && cnt_r == 2'h0 && !oerr_r) // [RULE3]
        else $error("flags not clear after reset");
    a_parity_off: assert property (push_ok && cnt_r == 2'h0 && !pop && !ctrl1_r[`URXEIW_C1_PEN]
                                   |=> !head[`URXEIW_E_PE]) // [RULE5]
        else $error("parity error raised with parity disabled");
    a_vector_gate: assert property (vector_r |-> !irq_n_r && $past(ints_on) && !$past(stack_full)) // [RULE8]
        else $error("vector without enables");
    a_pulse_cause: assert property (!irq_n_r |-> $past(evt) || $past(wake_evt)) // [RULE26]
        else $error("request pulse without event");
    a_addr_mask: assert property (ctrl2_r[`URXEIW_C2_ADDEN] && push_ok && !shift_nxt[8] && !ovr |-> !rx_evt) // [RULE12]
        else $error("data word requested in address mode");
    a_oerr_clear: assert property (oerr_r && data_rd && armed_r && !ovr |=> !oerr_r) // [RULE23]
        else $error("overrun not cleared by read sequence");
    a_oerr_hold: assert property (oerr_r && !(data_rd && armed_r) |=> oerr_r) // [RULE11]
        else $error("overrun cleared without read sequence");
    a_rx_freeze: assert property (s_frozen |-> $stable(bitn_r) && $stable(ovs_r) && $stable(shift_r)) // [RULE16]
        else $error("receiver moved while suspended");
    a_wake_pulse: assert property (wake_hit |=> wake_req_r && wake_pend_r ##1 !wake_req_r) // [RULE19]
        else $error("wake-up not signalled");
    a_wake_hold: assert property (startup && !wake_evt |=> irq_n_r) // [RULE22]
        else $error("request during start-up");
    a_wake_quiet: assert property (startup_cnt_r == 12'h001 && wake_pend_r && !ints_on |=> irq_n_r) // [RULE21]
        else $error("wake request without interrupt enables");

    sequence s_rx_word;
        push_ok && ctrl2_r[`URXEIW_C2_RIE] && !startup;
    endsequence
    sequence s_wake_done;
        wake_pend_r && startup_cnt_r == 12'h001 && ints_on;
    endsequence

    a_noise_push: assert property (push && noise_r |-> new_entry[`URXEIW_E_NF]) // [RULE24]
        else $error("noise flag lost");
    a_rx_every: assert property (s_rx_word and !ctrl2_r[`URXEIW_C2_ADDEN] |=> !irq_n_r) // [RULE13]
        else $error("data word not requested");
    a_addr_word: assert property (s_rx_word and shift_nxt[8] |=> !irq_n_r) // [RULE10]
        else $error("address word not requested");
    a_start_block: assert property (st_r == ST_IDLE && startup |=> st_r == ST_IDLE) // [RULE20]
        else $error("frame started during start-up");
    a_vector_on: assert property (evt && ints_on && !stack_full |=> vector_r) // [RULE8]
        else $error("vector missing");
    a_regs_halt: assert property (halt && !wr_en
                                  |=> $stable(ctrl1_r) && $stable(ctrl2_r) && $stable(baud_r)) // [RULE17]
        else $error("registers changed in sleep");
    a_tx_enable: assert property (tx_empty && !txe_prev_r && ctrl2_r[`URXEIW_C2_TXEIE] && !startup |=> !irq_n_r) // [RULE9]
        else $error("transmit empty not requested");
    a_overrun_irq: assert property (ovr && ctrl2_r[`URXEIW_C2_RIE] && !startup |=> !irq_n_r) // [RULE7]
        else $error("overrun not requested");
    a_wake_irq: assert property (s_wake_done |=> !irq_n_r) // [RULE22]
        else $error("wake request missing");
    a_div_freeze: assert property (!run |=> $stable(div_r)) // [RULE15]
        else $error("bit timer moved while stopped");
    a_stop_good: assert property (st_r == ST_STOP1 && tick && bit_end && maj && !ctrl1_r[`URXEIW_C1_TWO]
                                  |-> push && !new_entry[`URXEIW_E_FE]) // [RULE1]
        else $error("good stop bit flagged");
    a_break_word: assert property (s_stop1_low and shift_nxt == 9'h000 |-> new_entry[`URXEIW_E_FE]) // [RULE25]
        else $error("break without frame error");
    a_reset_idle: assert property ($rose(resetn) |-> st_r == ST_IDLE && !fe_r && irq_n_r) // [RULE3]
        else $error("receiver not idle after reset");
endmodule : urxeiw_core

/* File: pkg/urxeiw_defs.svh */
// How it works
// [RULE1] Stop bit sampled low sets frame error
// [RULE2] Two stop bits: either low sets error
// [RULE3] Reset clears frame error; stored with word
// [RULE4] Wrong odd/even parity sets parity error
// [RULE5] Parity checked only while parity enabled
// [RULE6] Software reads error flags before data
// [RULE7] Six sources make active-low request pulse
// [RULE8] Vector needs both enables, stack not full
// [RULE9] Own transmit enables; shared receive enable
// [RULE10] Address detect requests without own flag
// [RULE11] Flags read-only, cleared by module actions
// [RULE12] Address mode: request only if MSB high
// [RULE13] Address mode off: request every word
// [RULE14] Software clears parity with address mode
// [RULE15] Clock stop freezes transfer, then resumes
// [RULE16] Idle or sleep suspends reception
// [RULE17] Idle or sleep keeps registers unchanged
// [RULE18] Software finishes transfers before sleeping
// [RULE19] Falling receive edge while off wakes
// [RULE20] Receive data ignored during start-up
// [RULE21] Without interrupt enables, wake only
// [RULE22] Wake request held until start-up elapsed
// [RULE23] Overrun cleared by status then data read
// [RULE24] Noise flag rises with data available
// [RULE25] Break is all-zero word with frame error
// [RULE26] Request pulse lasts exactly one cycle
`ifndef URXEIW_DEFS_SVH
`define URXEIW_DEFS_SVH
// ----------------------------------------
// Register addresses
// ----------------------------------------
`define URXEIW_ADDR_STATUS 3'h0
`define URXEIW_ADDR_CTRL1 3'h1
`define URXEIW_ADDR_CTRL2 3'h2
`define URXEIW_ADDR_DATA 3'h3
`define URXEIW_ADDR_BAUD 3'h4
// ----------------------------------------
// Control fields
// ----------------------------------------
`define URXEIW_C1_MODE 7
`define URXEIW_C1_EN 6
`define URXEIW_C1_NINE 5
`define URXEIW_C1_PEN 4
`define URXEIW_C1_ODD 3
`define URXEIW_C1_TWO 2
`define URXEIW_C1_RX9 0
`define URXEIW_C2_TXEIE 7
`define URXEIW_C2_TXIIE 6
`define URXEIW_C2_RXEN 5
`define URXEIW_C2_RIE 4
`define URXEIW_C2_ADDEN 3
`define URXEIW_C2_WAKE 2
`define URXEIW_C1_WMASK 8'hfc
`define URXEIW_C2_WMASK 8'hfc
`define URXEIW_RST_BYTE 8'h00
// ----------------------------------------
// Receive entry fields
// ----------------------------------------
`define URXEIW_E_FE 9
`define URXEIW_E_PE 10
`define URXEIW_E_NF 11
// ----------------------------------------
// Timing
// ----------------------------------------
`define URXEIW_OVS_LAST 4'hf
`define URXEIW_SMP_A 4'h7
`define URXEIW_SMP_B 4'h8
`define URXEIW_SMP_C 4'h9
`define URXEIW_LAST8 4'h7
`define URXEIW_LAST9 4'h8
`define URXEIW_FIFO_FULL 2'h2
`define URXEIW_CLK_NS 4
`define URXEIW_STARTUP_NS 1024
`define URXEIW_STARTUP_CYC ((`URXEIW_STARTUP_NS + `URXEIW_CLK_NS - 1) / `URXEIW_CLK_NS)
`endif

/* File: pkg/urxeiw_pkg.sv */
package urxeiw_pkg;
    typedef logic [7:0] urxeiw_byte_t;
    typedef logic [2:0] urxeiw_addr_t;
    typedef logic [11:0] urxeiw_entry_t;
    typedef enum logic [5:0] {
        ST_IDLE = 6'h01,
        ST_START = 6'h02,
        ST_DATA = 6'h04,
        ST_PAR = 6'h08,
        ST_STOP1 = 6'h10,
        ST_STOP2 = 6'h20
    } urxeiw_state_t;
endpackage : urxeiw_pkg

/* File: tb/urxeiw_tx_model.sv */
module urxeiw_tx_model (
    input wire logic clk,
    output logic rx_line
);
    timeunit 1ns;
    timeprecision 1ps;
    // ----------------------------------------
    // Remote transmitter, line idles high
    // ----------------------------------------
    initial rx_line = 1'h1;

    // Holds one level on the line for n clocks
    task automatic put_bit(input logic b, input int n);
        rx_line <= b;
        repeat (n) @(posedge clk);
    endtask : put_bit

    // Start bit, data LSB first, optional parity, stop bits, then idle
    task automatic send(input logic [8:0] w, input int nb, input int bc, input logic pen, input logic odd,
                        input logic flip, input logic s1, input logic s2, input logic two);
        @(posedge clk);
        put_bit(1'h0, bc);
        for (int i = 0; i < nb; i++) put_bit(w[i], bc);
        if (pen) put_bit((^(w & {nb == 9, 8'hff})) ^ odd ^ flip, bc);
        put_bit(s1, bc);
        if (two) put_bit(s2, bc);
        put_bit(1'h1, bc);
    endtask : send
endmodule : urxeiw_tx_model

/* File: tb/tb_uart_rx_error_irq_wakeup.sv */
`include "urxeiw_defs.svh"
module tb_uart_rx_error_irq_wakeup import urxeiw_pkg::*; ;
    timeunit 1ns;
    timeprecision 1ps;
    // ----------------------------------------
    // Signals and monitors
    // ----------------------------------------
    logic clk = 1'h0;
    logic resetn, wr_en, rd_en, clk_on, halt, tx_empty, tx_idle, stack_full, rx_pin;
    logic global_interrupt_enable, serial_module_interrupt_enable, irq_n, vector_req, wake_req;
    urxeiw_addr_t addr;
    urxeiw_byte_t wdata, rdata, rv;
    int n_fail = 0, tests_run = 0, cyc = 0, n_irq = 0, n_lo = 0, n_vec = 0, n_wake = 0, e_irq = 0, e_vec = 0;
    logic irq_q = 1'h1;
    logic [31:0] seed = 32'hb41d;

    always #2 clk = ~clk;

    urxeiw_core DUT (.clk(clk), .resetn(resetn), .addr(addr), .wdata(wdata), .wr_en(wr_en), .rd_en(rd_en),
        .rdata(rdata), .rx_pin(rx_pin), .clk_on(clk_on), .halt(halt), .tx_empty(tx_empty), .tx_idle(tx_idle),
        .global_interrupt_enable(global_interrupt_enable), .stack_full(stack_full),
        .serial_module_interrupt_enable(serial_module_interrupt_enable),
        .irq_n(irq_n), .vector_req(vector_req), .wake_req(wake_req));
    urxeiw_tx_model u_tx (.clk(clk), .rx_line(rx_pin));

    always @(posedge clk) begin
        cyc <= cyc + 1;
        irq_q <= irq_n;
        if (resetn && !irq_n) n_lo <= n_lo + 1;
        if (resetn && !irq_n && irq_q) n_irq <= n_irq + 1;
        if (resetn && vector_req) n_vec <= n_vec + 1;
        if (resetn && wake_req) n_wake <= n_wake + 1;
        if (cyc == 30000) begin
            n_fail++;
            print_verdict();
        end
    end
    // ----------------------------------------
    // Helpers
    // ----------------------------------------
    function automatic logic [31:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction : rnd

    task automatic print_verdict();
        $display("checks %0d mismatches %0d", tests_run, n_fail);
        if (n_fail == 0 && tests_run > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask : print_verdict

    task automatic chk(input string nm, input logic [15:0] seen, input logic [15:0] exp);
        tests_run++;
        if (seen !== exp) begin
            n_fail++;
            $display("ERROR %s expected %h seen %h", nm, exp, seen);
        end
    endtask : chk

    task automatic wr(input urxeiw_addr_t a, input urxeiw_byte_t d);
        @(posedge clk);
        addr <= a;
        wdata <= d;
        wr_en <= 1'h1;
        @(posedge clk);
        wr_en <= 1'h0;
    endtask : wr

    task automatic rd(input urxeiw_addr_t a, output urxeiw_byte_t d);
        @(posedge clk);
        addr <= a;
        rd_en <= 1'h1;
        @(posedge clk);
        rd_en <= 1'h0;
        @(posedge clk);
        d = rdata;
    endtask : rd

    task automatic counts();
        chk("irq pulses", n_irq[15:0], e_irq[15:0]);
        chk("vectors", n_vec[15:0], e_vec[15:0]);
    endtask : counts

    task automatic bump();
        @(posedge clk);
        tx_empty <= 1'h0;
        repeat (5) @(posedge clk);
        tx_empty <= 1'h1;
        repeat (5) @(posedge clk);
    endtask : bump

    // One frame through the line, then status, bit 8 and data read back
    task automatic frame(input logic [8:0] w, input logic nine, input logic pen, input logic odd, input logic flip,
                         input logic s1, input logic s2, input logic two, input logic adden);
        logic fe;
        logic msb;
        fe = !s1 || (two && !s2);
        msb = nine ? w[8] : w[7];
        wr(`URXEIW_ADDR_CTRL1, {2'h3, nine, pen, odd, two, 2'h0});
        wr(`URXEIW_ADDR_CTRL2, {4'h3, adden, 3'h0});
        u_tx.send(w, nine ? 9 : 8, 16, pen, odd, flip, s1, s2, two);
        repeat (40) @(posedge clk);
        if (!adden || msb) begin
            e_irq++;
            e_vec++;
        end
        counts();
        rd(`URXEIW_ADDR_STATUS, rv);
        chk("status", {8'h0, rv[7:2]}, {8'h0, pen & flip, 1'h0, fe, 3'h3});
        rd(`URXEIW_ADDR_CTRL1, rv);
        chk("bit8", {15'h0, rv[0]}, {15'h0, nine & w[8]});
        rd(`URXEIW_ADDR_DATA, rv);
        chk("data", {8'h0, rv}, {8'h0, w[7:0]});
    endtask : frame
    // ----------------------------------------
    // Main sequence
    // ----------------------------------------
    initial begin
        logic [31:0] r;
        {resetn, wr_en, rd_en, halt, tx_empty, tx_idle, stack_full} = '0;
        {clk_on, global_interrupt_enable, serial_module_interrupt_enable} = '1;
        addr = '0;
        wdata = '0;
        repeat (10) @(posedge clk);
        resetn <= 1'h1;
        rd(`URXEIW_ADDR_STATUS, rv);
        chk("status reset", {8'h0, rv}, 16'h0008);
        rd(`URXEIW_ADDR_CTRL2, rv);
        chk("ctrl2 reset", {8'h0, rv}, 16'h0000);
        rd(3'h7, rv);
        chk("unmapped", {8'h0, rv}, 16'h0000);
        wr(`URXEIW_ADDR_STATUS, 8'hff);
        rd(`URXEIW_ADDR_STATUS, rv);
        chk("status write", {8'h0, rv}, 16'h0008);
        frame(9'h000, 1'h0, 1'h0, 1'h0, 1'h0, 1'h0, 1'h1, 1'h0, 1'h0);
        frame(9'h0a5, 1'h0, 1'h0, 1'h0, 1'h0, 1'h1, 1'h0, 1'h1, 1'h0);
        frame(9'h07f, 1'h0, 1'h0, 1'h0, 1'h0, 1'h1, 1'h1, 1'h0, 1'h1);
        frame(9'h100, 1'h1, 1'h0, 1'h0, 1'h0, 1'h1, 1'h1, 1'h0, 1'h1);
        for (int k = 0; k < 4; k++) frame(9'h0c3, 1'h0, 1'h1, k[0], k[1], 1'h1, 1'h1, 1'h0, 1'h0);
        for (int i = 0; i < 14; i++) begin
            r = rnd();
            frame(r[8:0], r[9], r[10] & !r[14], r[11], r[12], r[13] | r[15], r[16] | r[17], r[18], r[14]);
        end
        wr(`URXEIW_ADDR_CTRL1, 8'hc0);
        wr(`URXEIW_ADDR_CTRL2, 8'h30);
        for (int k = 0; k < 3; k++) u_tx.send(9'(8'h11 + k), 8, 16, 1'h0, 1'h0, 1'h0, 1'h1, 1'h1, 1'h0);
        repeat (40) @(posedge clk);
        e_irq += 3;
        e_vec += 3;
        counts();
        rd(`URXEIW_ADDR_DATA, rv);
        chk("first word", {8'h0, rv}, 16'h0011);
        rd(`URXEIW_ADDR_STATUS, rv);
        chk("overrun kept", {15'h0, rv[4]}, 16'h0001);
        rd(`URXEIW_ADDR_DATA, rv);
        chk("second word", {8'h0, rv}, 16'h0012);
        rd(`URXEIW_ADDR_STATUS, rv);
        chk("overrun cleared", {15'h0, rv[4]}, 16'h0000);
        wr(`URXEIW_ADDR_CTRL2, 8'hf0);
        tx_empty <= 1'h1;
        repeat (5) @(posedge clk);
        tx_idle <= 1'h1;
        repeat (5) @(posedge clk);
        e_irq += 2;
        e_vec += 2;
        counts();
        stack_full <= 1'h1;
        bump();
        e_irq++;
        counts();
        stack_full <= 1'h0;
        global_interrupt_enable <= 1'h0;
        bump();
        e_irq++;
        counts();
        global_interrupt_enable <= 1'h1;
        wr(`URXEIW_ADDR_CTRL2, 8'h30);
        bump();
        counts();
        halt <= 1'h1;
        rd(`URXEIW_ADDR_CTRL1, rv);
        halt <= 1'h0;
        chk("ctrl1 in sleep", {8'h0, rv}, 16'h00c0);
        wr(`URXEIW_ADDR_CTRL2, 8'h34);
        clk_on <= 1'h0;
        u_tx.put_bit(1'h0, 10);
        u_tx.put_bit(1'h1, 4);
        clk_on <= 1'h1;
        chk("wake", n_wake[15:0], 16'h0001);
        repeat (180) @(posedge clk);
        counts();
        repeat (100) @(posedge clk);
        e_irq++;
        e_vec++;
        counts();
        global_interrupt_enable <= 1'h0;
        clk_on <= 1'h0;
        u_tx.put_bit(1'h0, 10);
        u_tx.put_bit(1'h1, 4);
        clk_on <= 1'h1;
        u_tx.send(9'h0ff, 8, 16, 1'h0, 1'h0, 1'h0, 1'h1, 1'h1, 1'h0);
        repeat (150) @(posedge clk);
        chk("wake again", n_wake[15:0], 16'h0002);
        counts();
        rd(`URXEIW_ADDR_STATUS, rv);
        chk("ignored data", {15'h0, rv[2]}, 16'h0000);
        chk("pulse width", n_lo[15:0], n_irq[15:0]);
        print_verdict();
    end
endmodule : tb_uart_rx_error_irq_wakeup
